// File: rtl/two_level_irq_ctrl.sv
// Two-level vectored interrupt controller with flags, enables and nesting tracking
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"

module two_level_irq_ctrl
   import irq_ctrl_pkg::*;
#(
   parameter int EXT_PINS = 13
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire irq_ctrl_pkg::reg_req_t reg_req,
   output logic [7:0] rd_data_reg,
   input wire irq_ctrl_pkg::periph_events_t events,
   input wire logic [EXT_PINS-1:0] ext_pins,
   input wire logic instr_end,
   input wire logic return_from_interrupt,
   output irq_ctrl_pkg::irq_take_t irq_take_reg,
   output logic stop_wake_reg,
   output irq_ctrl_pkg::nest_state_t nest_state_reg
);
   import irq_ctrl_pkg::*;

   // ==========================================================
   // Functions
   function automatic logic [15:0] vector_of(input logic [3:0] idx);
      logic [15:0] v;
      v = `VEC_EXT0;
      case (idx)
         4'h0: v = `VEC_EXT0;
         4'h1: v = `VEC_TIMER0;
         4'h2: v = `VEC_EXT1;
         4'h3: v = `VEC_TIMER1;
         4'h4: v = `VEC_UART;
         4'h5: v = `VEC_TIMER2;
         4'h6: v = `VEC_ADC;
         4'h7: v = `VEC_SERIAL0;
         4'h8: v = `VEC_PULSE_GEN;
         4'h9: v = `VEC_BASE_TICK;
         4'ha: v = `VEC_EXT2;
         4'hb: v = `VEC_TIMER3;
         4'hc: v = `VEC_TIMER4;
         4'hd: v = `VEC_SERIAL1;
         4'he: v = `VEC_SERIAL2;
         default: v = `VEC_LOW_VOLTAGE;
      endcase
      return v;
   endfunction

   // Lowest index set; index order equals vector address order
   function automatic logic [3:0] first_set(input logic [15:0] bits);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 15; i >= 0; i--)
      begin
         if (bits[i])
         begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   // Spread the three 8-bit registers onto the 16 polling slots
   function automatic logic [15:0] spread(input logic [7:0] main_r, input logic [7:0] sec_r,
                                          input logic [7:0] third_r);
      logic [15:0] s;
      s = {third_r[7], third_r[1], third_r[0], sec_r[7], sec_r[6], sec_r[3], sec_r[2],
           sec_r[1], sec_r[0], main_r[6:0]};
      return s;
   endfunction

   // ==========================================================
   // Registers
   logic [7:0] enable_main_reg;
   logic [7:0] enable_sec_reg;
   logic [7:0] enable_third_reg;
   logic [7:0] priority_main_reg;
   logic [7:0] priority_sec_reg;
   logic [7:0] priority_third_reg;
   logic [EXT_PINS-1:0] ext_rising_edge_select_reg;
   logic [EXT_PINS-1:0] ext_falling_edge_select_reg;
   logic [15:0] flag_reg;
   logic uart_tx_done_flag_reg;
   logic [EXT_PINS-1:0] pin_sync1_reg;
   logic [EXT_PINS-1:0] pin_sync2_reg;
   logic [EXT_PINS-1:0] pin_sync3_reg;
   logic [EXT_PINS-1:0] pin_level_reg;

   logic wr_main_en;
   logic wr_sec_en;
   logic wr_third_en;
   logic wr_prio_main;
   logic wr_prio_sec;
   logic wr_prio_third;
   logic [15:0] sw_clear;
   logic sw_clear_tx;
   logic [15:0] hw_set;
   logic [15:0] hw_clear;
   logic [15:0] enables;
   logic [15:0] levels;
   logic [15:0] source_active;
   logic [15:0] requests;
   logic [15:0] high_req;
   logic [15:0] low_req;
   logic [EXT_PINS-1:0] pin_change;
   logic [EXT_PINS-1:0] pin_event;
   logic global_irq_enable;
   nest_state_t state_after_return;
   nest_state_t nest_state_next;
   logic take_now;
   logic take_high;
   logic [3:0] take_idx;

   assign wr_main_en = reg_req.wr_en && reg_req.addr == `IRQ_ENABLE_MAIN_OFS;
   assign wr_sec_en = reg_req.wr_en && reg_req.addr == `IRQ_ENABLE_SEC_OFS;
   assign wr_third_en = reg_req.wr_en && reg_req.addr == `IRQ_ENABLE_THIRD_OFS;
   assign wr_prio_main = reg_req.wr_en && reg_req.addr == `IRQ_PRIORITY_MAIN_OFS;
   assign wr_prio_sec = reg_req.wr_en && reg_req.addr == `IRQ_PRIORITY_SEC_OFS;
   assign wr_prio_third = reg_req.wr_en && reg_req.addr == `IRQ_PRIORITY_THIRD_OFS;

   // ==========================================================
   // Enable and priority registers
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enable_main_reg <= `IRQ_REG_RESET;
         enable_sec_reg <= `IRQ_REG_RESET;
         enable_third_reg <= `IRQ_REG_RESET;
      end
      else
      begin
         if (wr_main_en)
         begin
            enable_main_reg <= reg_req.wr_data & `MAIN_MASK;
         end
         if (wr_sec_en)
         begin
            enable_sec_reg <= reg_req.wr_data & `SEC_MASK;
         end
         if (wr_third_en)
         begin
            enable_third_reg <= reg_req.wr_data & `THIRD_MASK;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         priority_main_reg <= `IRQ_REG_RESET;
         priority_sec_reg <= `IRQ_REG_RESET;
         priority_third_reg <= `IRQ_REG_RESET;
      end
      else
      begin
         if (wr_prio_main)
         begin
            priority_main_reg <= reg_req.wr_data & `PRIO_MAIN_MASK;
         end
         if (wr_prio_sec)
         begin
            priority_sec_reg <= reg_req.wr_data & `SEC_MASK;
         end
         if (wr_prio_third)
         begin
            priority_third_reg <= reg_req.wr_data & `THIRD_MASK;
         end
      end
   end

   // Edge selects; a pin with both bits set fires on either edge
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ext_rising_edge_select_reg <= '0;
         ext_falling_edge_select_reg <= '0;
      end
      else
      begin
         if (reg_req.wr_en && reg_req.addr == `EXT_RISE_LOW_OFS)
         begin
            ext_rising_edge_select_reg[7:0] <= reg_req.wr_data;
         end
         if (reg_req.wr_en && reg_req.addr == `EXT_RISE_HIGH_OFS)
         begin
            ext_rising_edge_select_reg[EXT_PINS-1:8] <= reg_req.wr_data[EXT_PINS-9:0];
         end
         if (reg_req.wr_en && reg_req.addr == `EXT_FALL_LOW_OFS)
         begin
            ext_falling_edge_select_reg[7:0] <= reg_req.wr_data;
         end
         if (reg_req.wr_en && reg_req.addr == `EXT_FALL_HIGH_OFS)
         begin
            ext_falling_edge_select_reg[EXT_PINS-1:8] <= reg_req.wr_data[EXT_PINS-9:0];
         end
      end
   end

   // ==========================================================
   // External pins: three stages, a change counts once stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_sync1_reg <= '0;
         pin_sync2_reg <= '0;
         pin_sync3_reg <= '0;
         pin_level_reg <= '0;
      end
      else
      begin
         pin_sync1_reg <= ext_pins;
         pin_sync2_reg <= pin_sync1_reg;
         pin_sync3_reg <= pin_sync2_reg;
         for (int i = 0; i < EXT_PINS; i++)
         begin
            if (pin_change[i])
            begin
               pin_level_reg[i] <= pin_sync3_reg[i];
            end
         end
      end
   end

   assign pin_change = ~(pin_sync2_reg ^ pin_sync3_reg) & (pin_sync3_reg ^ pin_level_reg);
   assign pin_event = pin_change & ((pin_sync3_reg & ext_rising_edge_select_reg) |
                                    (~pin_sync3_reg & ext_falling_edge_select_reg));

   // ==========================================================
   // Flags
   always_comb
   begin
      hw_set = '0;
      hw_set[0] = |pin_event[2:0];
      hw_set[1] = events.timer0_overflow;
      hw_set[2] = |pin_event[6:3];
      hw_set[3] = events.timer1_overflow;
      hw_set[4] = events.uart_rx_done;
      hw_set[5] = events.timer2_overflow;
      hw_set[6] = events.adc_done;
      hw_set[7] = events.serial_done[0];
      hw_set[8] = events.pulse_gen_overflow;
      hw_set[9] = events.base_tick;
      hw_set[10] = |pin_event[12:7];
      hw_set[11] = events.timer3_overflow;
      hw_set[12] = events.timer4_overflow;
      hw_set[13] = events.serial_done[1];
      hw_set[14] = events.serial_done[2];
      hw_set[15] = events.low_voltage;
   end

   // Write one to clear
   always_comb
   begin
      sw_clear = '0;
      sw_clear_tx = 1'b0;
      if (reg_req.wr_en && reg_req.addr == `FLAG_LOW_OFS)
      begin
         sw_clear[7:0] = reg_req.wr_data;
      end
      else if (reg_req.wr_en && reg_req.addr == `FLAG_HIGH_OFS)
      begin
         sw_clear[15:8] = reg_req.wr_data;
      end
      else if (reg_req.wr_en && reg_req.addr == `FLAG_EXTRA_OFS)
      begin
         sw_clear_tx = reg_req.wr_data[0];
      end
   end

   // Acceptance clears only the self-clearing sources
   always_comb
   begin
      hw_clear = '0;
      if (take_now)
      begin
         hw_clear[take_idx] = `AUTO_CLEAR_MASK >> take_idx != 16'h0000 &&
                              (`AUTO_CLEAR_MASK & (16'h0001 << take_idx)) != 16'h0000;
      end
      // Converter flag drops when software starts a new conversion
      hw_clear[6] = events.adc_start;
   end

   // Set wins over any clear in the same cycle
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flag_reg <= '0;
         uart_tx_done_flag_reg <= 1'b0;
      end
      else
      begin
         flag_reg <= (flag_reg & ~sw_clear & ~hw_clear) | hw_set;
         uart_tx_done_flag_reg <= (uart_tx_done_flag_reg & ~sw_clear_tx) |
                                  events.uart_tx_done;
      end
   end

   // ==========================================================
   // Request gating and arbitration
   assign global_irq_enable = enable_main_reg[`GLOBAL_ENABLE_BIT];
   assign enables = spread(enable_main_reg, enable_sec_reg, enable_third_reg);
   assign levels = spread(priority_main_reg, priority_sec_reg, priority_third_reg);

   always_comb
   begin
      source_active = flag_reg;
      source_active[4] = flag_reg[4] | uart_tx_done_flag_reg;
   end

   assign requests = source_active & enables & {16{global_irq_enable}};
   assign high_req = requests & levels;
   assign low_req = requests & ~levels;

   always_comb
   begin
      state_after_return = nest_state_reg;
      if (return_from_interrupt)
      begin
         case (nest_state_reg)
            ST_HIGH_OVER_LOW: state_after_return = ST_LOW;
            ST_HIGH: state_after_return = ST_IDLE;
            ST_LOW: state_after_return = ST_IDLE;
            default: state_after_return = ST_IDLE;
         endcase
      end
   end

   // Low may be taken only when idle; high unless a high one runs
   always_comb
   begin
      take_high = 1'b0;
      take_now = 1'b0;
      take_idx = 4'h0;
      if (instr_end)
      begin
         case (state_after_return)
            ST_IDLE:
            begin
               take_now = |requests;
               take_high = |high_req;
               take_idx = take_high ? first_set(high_req) : first_set(low_req);
            end
            ST_LOW:
            begin
               take_now = |high_req;
               take_high = 1'b1;
               take_idx = first_set(high_req);
            end
            default:
            begin
               take_now = 1'b0;
            end
         endcase
      end
   end

   always_comb
   begin
      nest_state_next = state_after_return;
      if (take_now)
      begin
         case (state_after_return)
            ST_IDLE: nest_state_next = take_high ? ST_HIGH : ST_LOW;
            ST_LOW: nest_state_next = ST_HIGH_OVER_LOW;
            default: nest_state_next = state_after_return;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         nest_state_reg <= ST_IDLE;
      end
      else
      begin
         nest_state_reg <= nest_state_next;
      end
   end

   // Core loads the vector on this pulse and pushes its return address
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_take_reg <= '0;
      end
      else
      begin
         irq_take_reg.valid <= take_now;
         irq_take_reg.high_level <= take_now & take_high;
         irq_take_reg.vector <= take_now ? vector_of(take_idx) : 16'h0000;
      end
   end

   // Wake works without the global enable so stop can be left
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stop_wake_reg <= 1'b0;
      end
      else
      begin
         stop_wake_reg <= |(source_active & enables & 16'h0405);
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_data_reg <= 8'h00;
      end
      else if (!reg_req.rd_en)
      begin
         rd_data_reg <= 8'h00;
      end
      else if (reg_req.addr == `IRQ_ENABLE_MAIN_OFS)
      begin
         rd_data_reg <= enable_main_reg;
      end
      else if (reg_req.addr == `IRQ_ENABLE_SEC_OFS)
      begin
         rd_data_reg <= enable_sec_reg;
      end
      else if (reg_req.addr == `IRQ_ENABLE_THIRD_OFS)
      begin
         rd_data_reg <= enable_third_reg;
      end
      else if (reg_req.addr == `IRQ_PRIORITY_MAIN_OFS)
      begin
         rd_data_reg <= priority_main_reg;
      end
      else if (reg_req.addr == `IRQ_PRIORITY_SEC_OFS)
      begin
         rd_data_reg <= priority_sec_reg;
      end
      else if (reg_req.addr == `IRQ_PRIORITY_THIRD_OFS)
      begin
         rd_data_reg <= priority_third_reg;
      end
      else if (reg_req.addr == `FLAG_LOW_OFS)
      begin
         rd_data_reg <= flag_reg[7:0];
      end
      else if (reg_req.addr == `FLAG_HIGH_OFS)
      begin
         rd_data_reg <= flag_reg[15:8];
      end
      else if (reg_req.addr == `FLAG_EXTRA_OFS)
      begin
         rd_data_reg <= {7'h00, uart_tx_done_flag_reg};
      end
      else if (reg_req.addr == `EXT_RISE_LOW_OFS)
      begin
         rd_data_reg <= ext_rising_edge_select_reg[7:0];
      end
      else if (reg_req.addr == `EXT_RISE_HIGH_OFS)
      begin
         rd_data_reg <= {3'h0, ext_rising_edge_select_reg[EXT_PINS-1:8]};
      end
      else if (reg_req.addr == `EXT_FALL_LOW_OFS)
      begin
         rd_data_reg <= ext_falling_edge_select_reg[7:0];
      end
      else if (reg_req.addr == `EXT_FALL_HIGH_OFS)
      begin
         rd_data_reg <= {3'h0, ext_falling_edge_select_reg[EXT_PINS-1:8]};
      end
      else
      begin
         rd_data_reg <= 8'h00;
      end
   end

endmodule

// File: rtl/irq_ctrl_cfg.svh
// Register offsets, field positions, reset values and vectors of the interrupt controller
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

// ==========================================================
// Register offsets
`define IRQ_ENABLE_MAIN_OFS 8'ha8
`define IRQ_ENABLE_SEC_OFS 8'ha9
`define IRQ_ENABLE_THIRD_OFS 8'haa
`define IRQ_PRIORITY_MAIN_OFS 8'hb8
`define IRQ_PRIORITY_SEC_OFS 8'hb9
`define IRQ_PRIORITY_THIRD_OFS 8'hba
`define FLAG_LOW_OFS 8'hc0
`define FLAG_HIGH_OFS 8'hc1
`define FLAG_EXTRA_OFS 8'hc2
`define EXT_RISE_LOW_OFS 8'hc8
`define EXT_RISE_HIGH_OFS 8'hc9
`define EXT_FALL_LOW_OFS 8'hca
`define EXT_FALL_HIGH_OFS 8'hcb

// ==========================================================
// Reset values and writable bits
`define IRQ_REG_RESET 8'h00
`define MAIN_MASK 8'hff
`define PRIO_MAIN_MASK 8'h7f
`define SEC_MASK 8'hcf
`define THIRD_MASK 8'h83
`define EXT_HIGH_MASK 8'h1f
`define GLOBAL_ENABLE_BIT 7

// ==========================================================
// Vector addresses, indexed by polling order
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001b
`define VEC_UART 16'h0023
`define VEC_TIMER2 16'h002b
`define VEC_ADC 16'h0033
`define VEC_SERIAL0 16'h003b
`define VEC_PULSE_GEN 16'h0043
`define VEC_BASE_TICK 16'h004b
`define VEC_EXT2 16'h0053
`define VEC_TIMER3 16'h006b
`define VEC_TIMER4 16'h0073
`define VEC_SERIAL1 16'h007b
`define VEC_SERIAL2 16'h0083
`define VEC_LOW_VOLTAGE 16'h00b3

// Sources whose flag hardware clears on acceptance
`define AUTO_CLEAR_MASK 16'h060f

`endif

// File: rtl/irq_ctrl_pkg.sv
// Types shared by the interrupt controller and its users
package irq_ctrl_pkg;

   // ==========================================================
   // Nesting state, one-hot
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_LOW = 4'b0010,
      ST_HIGH = 4'b0100,
      ST_HIGH_OVER_LOW = 4'b1000
   } nest_state_t;

   // ==========================================================
   // Hardware events, one-cycle pulses on core_clk
   typedef struct packed
   {
      logic timer0_overflow;
      logic timer1_overflow;
      logic timer2_overflow;
      logic timer3_overflow;
      logic timer4_overflow;
      logic uart_rx_done;
      logic uart_tx_done;
      logic adc_start;
      logic adc_done;
      logic [2:0] serial_done;
      logic pulse_gen_overflow;
      logic base_tick;
      logic low_voltage;
   } periph_events_t;

   // ==========================================================
   // Vector handed to the core
   typedef struct packed
   {
      logic valid;
      logic high_level;
      logic [15:0] vector;
   } irq_take_t;

   // ==========================================================
   // Register bus request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wr_data;
      logic wr_en;
      logic rd_en;
   } reg_req_t;

endpackage

// File: test/irq_ctrl_chk.sv
// Port assertions for the two-level interrupt controller
`timescale 1ns/1ps
module irq_ctrl_chk
   import irq_ctrl_pkg::*;
#(
   parameter int EXT_PINS = 13
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire irq_ctrl_pkg::reg_req_t reg_req,
   input wire logic [7:0] rd_data_reg,
   input wire irq_ctrl_pkg::periph_events_t events,
   input wire logic [EXT_PINS-1:0] ext_pins,
   input wire logic instr_end,
   input wire logic return_from_interrupt,
   input wire irq_ctrl_pkg::irq_take_t irq_take_reg,
   input wire logic stop_wake_reg,
   input wire irq_ctrl_pkg::nest_state_t nest_state_reg
);
   logic global_reg;
   // ==========================================================
   // Shadow of the global enable, kept from bus writes
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         global_reg <= 1'b0;
      else if (reg_req.wr_en && reg_req.addr == 8'ha8)
         global_reg <= reg_req.wr_data[7];
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   chk_take_on_end: assert property (irq_take_reg.valid |-> $past(instr_end))
      else $error("take without instruction end");
   chk_take_gated: assert property (irq_take_reg.valid |-> $past(global_reg))
      else $error("take while globally disabled");
   chk_vector_known: assert property (irq_take_reg.valid
      |-> irq_take_reg.vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
      16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h006b, 16'h0073,
      16'h007b, 16'h0083, 16'h00b3})
      else $error("unknown vector");
   chk_high_not_preempted: assert property (irq_take_reg.valid && irq_take_reg.high_level
      && !return_from_interrupt |=> !irq_take_reg.valid) else $error("high routine preempted");
   chk_high_nest: assert property (irq_take_reg.valid && irq_take_reg.high_level
      |-> nest_state_reg inside {ST_HIGH, ST_HIGH_OVER_LOW}) else $error("bad high nesting");
   chk_low_nest: assert property (irq_take_reg.valid && !irq_take_reg.high_level
      |-> nest_state_reg == ST_LOW) else $error("bad low nesting");
   chk_idle_quiet: assert property (!irq_take_reg.valid
      |-> irq_take_reg.vector == 16'h0000 && !irq_take_reg.high_level) else $error("stale vector");
   chk_read_window: assert property (!$past(reg_req.rd_en) |-> rd_data_reg == 8'h00)
      else $error("read data outside window");
   chk_prio_reserved: assert property ($past(reg_req.rd_en) && $past(reg_req.addr) == 8'hb8
      |-> !rd_data_reg[7]) else $error("reserved bit reads one");
endmodule
bind two_level_irq_ctrl irq_ctrl_chk #(.EXT_PINS(EXT_PINS)) u_chk (.core_clk(core_clk),
   .reset_n(reset_n), .reg_req(reg_req), .rd_data_reg(rd_data_reg), .events(events),
   .ext_pins(ext_pins), .instr_end(instr_end), .return_from_interrupt(return_from_interrupt),
   .irq_take_reg(irq_take_reg), .stop_wake_reg(stop_wake_reg), .nest_state_reg(nest_state_reg));

// File: test/core_model.sv
// Behavioural core: instruction boundaries and one return per take
`timescale 1ns/1ps
module core_model
   import irq_ctrl_pkg::*;
#(
   parameter int HOLD = 8
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic run,
   input wire irq_ctrl_pkg::irq_take_t irq_take_reg,
   output logic instr_end,
   output logic return_from_interrupt
);
   int cnt;
   int depth;
   // ==========================================================
   // Innermost routine returns HOLD+1 cycles after the last take or return
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         instr_end <= 1'b0;
         return_from_interrupt <= 1'b0;
         cnt <= 0;
         depth <= 0;
      end
      else
      begin
         instr_end <= run;
         return_from_interrupt <= 1'b0;
         if (irq_take_reg.valid)
         begin
            cnt <= 0;
            depth <= depth + 1;
         end
         else if (depth > 0 && cnt == HOLD)
         begin
            cnt <= 0;
            depth <= depth - 1;
            return_from_interrupt <= 1'b1;
         end
         else
            cnt <= cnt + 1;
      end
   end
endmodule

// File: test/tb_two_level_irq_ctrl.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module tb_two_level_irq_ctrl;
   import irq_ctrl_pkg::*;
   logic core_clk, reset_n, instr_end, return_from_interrupt, stop_wake_reg, run;
   reg_req_t reg_req;
   logic [7:0] rd_data_reg;
   periph_events_t events;
   logic [12:0] ext_pins;
   irq_take_t irq_take_reg;
   nest_state_t nest_state_reg;
   int bad_count, tests_run;
   logic [16:0] taken[$], exp[$];
   logic [15:0] vec_tab [16] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
      16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h006b, 16'h0073, 16'h007b, 16'h0083,
      16'h00b3};
   two_level_irq_ctrl u_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
      .rd_data_reg(rd_data_reg), .events(events), .ext_pins(ext_pins), .instr_end(instr_end),
      .return_from_interrupt(return_from_interrupt), .irq_take_reg(irq_take_reg),
      .stop_wake_reg(stop_wake_reg), .nest_state_reg(nest_state_reg));
   core_model u_core (.core_clk(core_clk), .reset_n(reset_n), .run(run),
      .irq_take_reg(irq_take_reg), .instr_end(instr_end),
      .return_from_interrupt(return_from_interrupt));
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (irq_take_reg.valid === 1'b1)
         taken.push_back({irq_take_reg.high_level, irq_take_reg.vector});
   // ==========================================================
   // Bus, event and checking helpers
   task automatic complete_run();
      if (bad_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [16:0] got, input logic [16:0] want);
      tests_run++;
      if (got !== want)
      begin
         bad_count++;
         $display("FAIL %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) reg_req.wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge core_clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) reg_req.rd_en <= 1'b0;
      #1 check({9'h000, rd_data_reg}, {9'h000, want});
   endtask
   task automatic fire(input periph_events_t e);
      @(posedge core_clk) events <= e;
      @(posedge core_clk) events <= '0;
   endtask
   function automatic periph_events_t ev(input int s);
      periph_events_t e;
      e = '0;
      case (s)
         1: e.timer0_overflow = 1'b1;
         3: e.timer1_overflow = 1'b1;
         4: e.uart_rx_done = 1'b1;
         5: e.timer2_overflow = 1'b1;
         6: e.adc_done = 1'b1;
         7: e.serial_done[0] = 1'b1;
         8: e.pulse_gen_overflow = 1'b1;
         9: e.base_tick = 1'b1;
         11: e.timer3_overflow = 1'b1;
         12: e.timer4_overflow = 1'b1;
         13: e.serial_done[1] = 1'b1;
         14: e.serial_done[2] = 1'b1;
         15: e.low_voltage = 1'b1;
         default: e = '0;
      endcase
      return e;
   endfunction
   task automatic wait_q(input int n);
      for (int i = 0; i < 200 && taken.size() < n; i++)
         @(posedge core_clk);
      if (taken.size() < n)
      begin
         bad_count++;
         $display("FAIL %0t no vector taken", $time);
         complete_run();
      end
   endtask
   // Runs the core, then compares every take against exp in order
   task automatic expect_takes();
      @(posedge core_clk) run <= 1'b1;
      wait_q(exp.size());
      repeat (exp.size() == 0 ? 30 : 1) @(posedge core_clk);
      run <= 1'b0;
      repeat (30) @(posedge core_clk);
      check(17'(taken.size()), 17'(exp.size()));
      foreach (exp[i])
         check(taken[i], exp[i]);
      taken = {};
   endtask
   task automatic cfg(input logic [7:0] e0, input logic [7:0] p0, input logic [7:0] p1);
      wr(8'ha8, e0);
      wr(8'ha9, 8'hff);
      wr(8'haa, 8'hff);
      wr(8'hb8, p0);
      wr(8'hb9, p1);
      wr(8'hba, 8'h00);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] a [7] = '{8'ha8, 8'ha9, 8'haa, 8'hb8, 8'hb9, 8'hba, 8'h10};
      logic [7:0] m [7] = '{8'hff, 8'hcf, 8'h83, 8'h7f, 8'hcf, 8'h83, 8'h00};
      for (int i = 0; i < 7; i++)
      begin
         rd(a[i], 8'h00);
         wr(a[i], 8'hff);
         rd(a[i], m[i]);
      end
   endtask
   task automatic t_gate();
      cfg(8'h7f, 8'h00, 8'h00);
      fire(ev(1));
      expect_takes();
      wr(8'ha8, 8'hff);
      exp = {17'h0000b};
      expect_takes();
      rd(8'hc0, 8'h00);
   endtask
   task automatic t_vectors();
      logic [15:0] hw_clr = 16'h060f;
      logic [7:0] fa, fb;
      periph_events_t st;
      st = '0;
      st.adc_start = 1'b1;
      cfg(8'hff, 8'h00, 8'h00);
      wr(8'hc8, 8'hff);
      wr(8'hc9, 8'h1f);
      for (int s = 0; s < 16; s++)
      begin
         fa = s < 8 ? 8'hc0 : 8'hc1;
         fb = 8'h01 << (s % 8);
         if (s == 0 || s == 2 || s == 10)
         begin
            check({16'h0000, stop_wake_reg}, 17'h00000);
            @(posedge core_clk) ext_pins <= 13'h0001 << (s == 0 ? 0 : s == 2 ? 3 : 7);
            repeat (8) @(posedge core_clk);
            check({16'h0000, stop_wake_reg}, 17'h00001);
            ext_pins <= '0;
         end
         else
            fire(ev(s));
         exp = {{1'b0, vec_tab[s]}};
         expect_takes();
         if (s == 6)
            fire(st);
         rd(fa, (hw_clr[s] || s == 6) ? 8'h00 : fb);
         wr(fa, fb);
      end
   endtask
   task automatic t_order();
      cfg(8'hff, 8'h00, 8'h04);
      fire(ev(1) | ev(3) | ev(9));
      exp = {17'h1004b, 17'h0000b, 17'h0001b};
      expect_takes();
   endtask
   task automatic t_preempt();
      fire(ev(1) | ev(3));
      @(posedge core_clk) run <= 1'b1;
      wait_q(1);
      fire(ev(9));
      exp = {17'h0000b, 17'h1004b, 17'h0001b};
      expect_takes();
   endtask
   // Transmit-done shares the UART request; a clear meeting a set loses
   task automatic t_tx();
      periph_events_t tx;
      tx = '0;
      tx.uart_tx_done = 1'b1;
      fire(tx);
      exp = {17'h00023};
      expect_takes();
      fork
         wr(8'hc2, 8'h01);
         fire(tx);
      join
      rd(8'hc2, 8'h01);
      wr(8'hc2, 8'h01);
      rd(8'hc2, 8'h00);
   endtask
   initial
   begin
      reset_n = 1'b0;
      reg_req = '0;
      events = '0;
      ext_pins = '0;
      run = 1'b0;
      bad_count = 0;
      tests_run = 0;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      t_regs();
      t_gate();
      t_vectors();
      t_order();
      t_preempt();
      t_tx();
      complete_run();
   end
endmodule
